// ==== rtl/uthf_tx_port.sv ====
// Endpoint-indexed transmit FIFO data port and hub change byte.
// Assumes an APB master and an interface engine on the same clock.
//
// Behaviour
// - Low five bits report hub and ports
// - Bit one means change pending
// - Hub IN token sends byte when nonzero
// - Hub IN token with no change NAKs
// - Index 81H selects hub byte, else data
// - Port change register sets its hub bit
// - Bits clear only via their cause
// - Bits 7 to 5 reserved
// - Data writes push into selected FIFO
// - Write pointer increments per accepted write, holds when full
// - Set flags step on count and advance
module uthf_tx_port #(
   parameter int NUM_EP = 4,
   parameter int DEPTH  = 8
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        tok_valid,
   input  wire logic [7:0]  tok_ep,
   input  wire logic        rd_req,
   input  wire logic [7:0]  rd_ep,
   output logic [7:0]       rd_data,
   output logic             rd_valid,
   input  wire logic        adv_valid,
   input  wire logic [7:0]  adv_ep,
   output logic             hub_send,
   output logic [7:0]       hub_byte,
   output logic             nak,
   output logic             irq
);

   localparam int SW = $clog2(NUM_EP);
   localparam int AW = $clog2(DEPTH);
   localparam int MW = $clog2(NUM_EP * DEPTH);
   localparam int IRQ_WD = uthf_pkg::IRQ_W;

   // Endpoint slot from index value
   function automatic logic [SW-1:0] slot(input logic [7:0] idx);
      slot = SW'(idx[6:0] % 7'(NUM_EP));
   endfunction

   // Index of the hub change byte
   function automatic logic is_hub(input logic [7:0] idx);
      is_hub = (idx == uthf_pkg::EP_HUB_STATUS);
   endfunction

   // Storage address of a slot and pointer
   function automatic logic [MW-1:0] maddr(
      input logic [SW-1:0] s,
      input logic [AW:0]   p
   );
      maddr = MW'(s * DEPTH) + MW'(p[AW-1:0]);
   endfunction

   // Registers
   logic [7:0]         sel_q;
   logic [31:0]        prdata_q;
   logic               pready_q;
   logic               pslverr_q;
   logic [7:0]         rd_data_q;
   logic               rd_valid_q;
   logic               hub_send_q;
   logic [7:0]         hub_byte_q;
   logic               nak_q;
   logic               irq_q;
   logic [IRQ_WD-1:0]  ists_q;
   logic [IRQ_WD-1:0]  ien_q;
   logic [4:0]         chg_q;
   logic [AW:0]        wp_q [NUM_EP];
   logic [AW:0]        rp_q [NUM_EP];
   logic [7:0]         mem_q [NUM_EP * DEPTH];

   // Bus decode
   wire [9:0]  widx    = paddr[11:2];
   wire        setup   = psel && !penable;
   wire        wr_acc  = psel && penable && pwrite && pready_q;
   wire [7:0]  wbyte   = pwdata[7:0];
   wire        hub_sel = is_hub(sel_q);
   wire [SW-1:0] wslot = slot(sel_q);

   wire hit_port  = (widx == uthf_pkg::IDX_TX_BYTE_PORT);
   wire hit_flag  = (widx == uthf_pkg::IDX_TX_FLAG_REG);
   wire hit_sel   = (widx == uthf_pkg::IDX_ENDPOINT_SEL);
   wire hit_cnt   = (widx == uthf_pkg::IDX_TX_BYTE_COUNT);
   wire hit_adv   = (widx == uthf_pkg::IDX_ADVANCE_MARKER);
   wire hit_pchg  = (widx >= uthf_pkg::IDX_PORT_CHANGE_0) &&
                    (widx < uthf_pkg::IDX_PORT_CHANGE_0 +
                     10'(uthf_pkg::HUB_BITS));
   wire hit_ists  = (widx == uthf_pkg::IDX_IRQ_STATUS);
   wire hit_ien   = (widx == uthf_pkg::IDX_IRQ_ENABLE);
   wire hit_iclr  = (widx == uthf_pkg::IDX_IRQ_CLEAR);
   wire mapped    = hit_port || hit_flag || hit_sel || hit_cnt ||
                    hit_adv || hit_pchg || hit_ists || hit_ien ||
                    hit_iclr;

   // Write strobes per register
   wire wr_sel  = wr_acc && hit_sel;
   wire wr_ien  = wr_acc && hit_ien;
   wire wr_iclr = wr_acc && hit_iclr;
   wire wr_pchg = wr_acc && hit_pchg;

   wire [2:0] pchg_idx = 3'(widx - uthf_pkg::IDX_PORT_CHANGE_0);

   // Per slot status
   wire [NUM_EP-1:0] full;
   wire [NUM_EP-1:0] empty;
   wire [1:0]        set_flags [NUM_EP];
   wire [NUM_EP-1:0] set_ovf;

   // Hub change byte
   wire [uthf_pkg::HUB_BITS-1:0] chg;
   wire [7:0]                    pchg_rdata;
   wire [7:0] hub_word = {3'b000, chg};

   uthf_hub_change u_hub (
      .clk   (clk),
      .rst   (rst),
      .wr    (wr_pchg),
      .sel   (pchg_idx),
      .wdata (wbyte),
      .rsel  (pchg_idx),
      .rdata (pchg_rdata),
      .chg   (chg)
   );

   // Data port push; hub byte is not writable
   wire push_try = wr_acc && hit_port && !hub_sel;
   wire push     = push_try && !full[wslot];
   wire push_ovf = push_try && full[wslot];

   // Engine reads and marker advances
   wire [SW-1:0] rslot = slot(rd_ep);
   wire          pop   = rd_req && !is_hub(rd_ep) &&
                         !empty[rslot];
   wire [SW-1:0] aslot = slot(adv_ep);
   wire fw_adv  = wr_acc && hit_adv && !hub_sel;
   wire fw_cnt  = wr_acc && hit_cnt && !hub_sel;

   // Hub token handling
   wire hub_tok = tok_valid && is_hub(tok_ep);
   wire hub_any = |chg;
   wire hub_ack = hub_tok && hub_any;
   wire hub_nak = hub_tok && !hub_any;

   genvar g;
   generate
      for (g = 0; g < NUM_EP; g++) begin : g_ep
         wire adv_here = (fw_adv && wslot == SW'(g)) ||
                         (adv_valid && aslot == SW'(g) &&
                          !is_hub(adv_ep));
         assign full[g]  = (wp_q[g] - rp_q[g]) == (AW+1)'(DEPTH);
         assign empty[g] = (wp_q[g] == rp_q[g]);

         uthf_set_flags u_flags (
            .clk    (clk),
            .rst    (rst),
            .cnt_wr (fw_cnt && wslot == SW'(g)),
            .adv    (adv_here),
            .flags  (set_flags[g]),
            .ovf    (set_ovf[g])
         );
      end
   endgenerate

   // Flag register view of the selected slot
   wire [7:0] flag_word;
   assign flag_word[uthf_pkg::FLG_SET1]  = set_flags[wslot][1];
   assign flag_word[uthf_pkg::FLG_SET0]  = set_flags[wslot][0];
   assign flag_word[5:4]                 = 2'b00;
   assign flag_word[uthf_pkg::FLG_EMPTY] = empty[wslot];
   assign flag_word[uthf_pkg::FLG_FULL]  = full[wslot];
   assign flag_word[1]                   = 1'b0;
   assign flag_word[uthf_pkg::FLG_OVF]   = 1'b0;

   // Read mux
   wire [7:0] port_rd = hub_sel ? hub_word : 8'h00;
   wire [31:0] rd_mux =
      hit_port ? {24'h000000, port_rd} :
      hit_flag ? {24'h000000, flag_word} :
      hit_sel  ? {24'h000000, sel_q} :
      hit_pchg ? {24'h000000, pchg_rdata} :
      hit_ists ? 32'(ists_q) :
      hit_ien  ? 32'(ien_q) :
      32'h00000000;

   // Interrupt events
   wire [IRQ_WD-1:0] ev;
   assign ev[uthf_pkg::IRQ_HUB_CHANGE] = |(chg & ~chg_q);
   assign ev[uthf_pkg::IRQ_NAK]        = hub_nak;
   assign ev[uthf_pkg::IRQ_OVERFLOW]   = push_ovf || (|set_ovf);

   wire [IRQ_WD-1:0] iclr =
      wr_iclr ? pwdata[IRQ_WD-1:0] : '0;
   wire [IRQ_WD-1:0] ists_d = (ists_q & ~iclr) | ev;

   // Bus slave: answer prepared in the setup cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !mapped;
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= rd_mux;
      end
   end

   // Endpoint select
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_q <= uthf_pkg::SEL_RESET;
      end else if (wr_sel) begin
         sel_q <= wbyte;
      end
   end

   // Interrupt enable
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ien_q <= '0;
      end else if (wr_ien) begin
         ien_q <= pwdata[IRQ_WD-1:0];
      end
   end

   // Interrupt status, set wins over clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ists_q <= '0;
      end else begin
         ists_q <= ists_d;
      end
   end

   // Change bits of the last cycle, for rise detection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chg_q <= 5'h00;
      end else begin
         chg_q <= chg;
      end
   end

   // Interrupt line
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ists_d & ien_q);
      end
   end

   // Write pointers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_EP; i++) begin
            wp_q[i] <= '0;
         end
      end else if (push) begin
         wp_q[wslot] <= wp_q[wslot] + 1'b1;
      end
   end

   // Read pointers, moved only by engine reads
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_EP; i++) begin
            rp_q[i] <= '0;
         end
      end else if (pop) begin
         rp_q[rslot] <= rp_q[rslot] + 1'b1;
      end
   end

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[maddr(wslot, wp_q[wslot])] <= wbyte;
      end
   end

   // Engine byte read strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_valid_q <= 1'b0;
      end else begin
         rd_valid_q <= pop;
      end
   end

   // Engine byte read data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data_q <= 8'h00;
      end else if (pop) begin
         rd_data_q <= mem_q[maddr(rslot, rp_q[rslot])];
      end
   end

   // Hub token answer pulses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hub_send_q <= 1'b0;
         nak_q      <= 1'b0;
      end else begin
         hub_send_q <= hub_ack;
         nak_q      <= hub_nak;
      end
   end

   // Hub byte as last sent
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hub_byte_q <= uthf_pkg::HUB_BYTE_RESET;
      end else if (hub_ack) begin
         hub_byte_q <= hub_word;
      end
   end

   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign rd_data  = rd_data_q;
   assign rd_valid = rd_valid_q;
   assign hub_send = hub_send_q;
   assign hub_byte = hub_byte_q;
   assign nak      = nak_q;
   assign irq      = irq_q;

endmodule

// ==== rtl/uthf_pkg.sv ====
// Constants of the transmit FIFO and hub change port.
// Assumes an APB slave with 32-bit data, one word per register.
package uthf_pkg;

   // Register indexes; byte address is four times the index
   localparam logic [9:0] IDX_TX_BYTE_PORT   = 10'h0F3;
   localparam logic [9:0] IDX_TX_FLAG_REG    = 10'h0F5;
   localparam logic [9:0] IDX_ENDPOINT_SEL   = 10'h0F1;
   localparam logic [9:0] IDX_TX_BYTE_COUNT  = 10'h0F6;
   localparam logic [9:0] IDX_ADVANCE_MARKER = 10'h0F7;
   localparam logic [9:0] IDX_PORT_CHANGE_0  = 10'h0E0;
   localparam logic [9:0] IDX_IRQ_STATUS     = 10'h0E8;
   localparam logic [9:0] IDX_IRQ_ENABLE     = 10'h0E9;
   localparam logic [9:0] IDX_IRQ_CLEAR      = 10'h0EA;

   // Endpoint index values
   localparam logic [7:0] EP_HUB_STATUS = 8'h81;
   localparam logic [7:0] EP_HUB_CTRL   = 8'h80;

   // Hub change byte layout
   localparam int HUB_BITS = 5;
   localparam logic [7:0] HUB_BYTE_RESET = 8'h00;

   // Flag register fields
   localparam int FLG_SET1  = 7;
   localparam int FLG_SET0  = 6;
   localparam int FLG_EMPTY = 3;
   localparam int FLG_FULL  = 2;
   localparam int FLG_OVF   = 0;

   // Interrupt status bits
   localparam int IRQ_W          = 3;
   localparam int IRQ_HUB_CHANGE = 0;
   localparam int IRQ_NAK        = 1;
   localparam int IRQ_OVERFLOW   = 2;

   localparam logic [7:0] SEL_RESET = 8'h00;

   typedef enum logic [1:0] {
      SET_NONE = 2'b00,
      SET_ONE  = 2'b01,
      SET_HI   = 2'b10,
      SET_TWO  = 2'b11
   } uthf_set_type;

endpackage

// ==== rtl/uthf_set_flags.sv ====
// Two set-index flags of one transmit FIFO.
// Assumes count writes and marker advances are one-cycle pulses.
module uthf_set_flags (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       cnt_wr,
   input  wire logic       adv,
   output logic [1:0]      flags,
   output logic            ovf
);

   uthf_pkg::uthf_set_type st_q;
   uthf_pkg::uthf_set_type st_d;

   always_comb begin
      st_d = st_q;
      ovf  = 1'b0;
      if (cnt_wr) begin
         case (st_q)
            uthf_pkg::SET_NONE: st_d = uthf_pkg::SET_ONE;
            uthf_pkg::SET_ONE:  st_d = uthf_pkg::SET_TWO;
            uthf_pkg::SET_HI:   st_d = uthf_pkg::SET_TWO;
            uthf_pkg::SET_TWO:  ovf  = 1'b1;
            default:            st_d = uthf_pkg::SET_NONE;
         endcase
      end else if (adv) begin
         case (st_q)
            uthf_pkg::SET_TWO: st_d = uthf_pkg::SET_HI;
            default:           st_d = uthf_pkg::SET_NONE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= uthf_pkg::SET_NONE;
      end else begin
         st_q <= st_d;
      end
   end

   assign flags = st_q;

endmodule

// ==== rtl/uthf_hub_change.sv ====
// Hub and downstream port change registers.
// Assumes index 0 is the hub itself, 1 to 4 the ports.
module uthf_hub_change (
   input  wire logic                          clk,
   input  wire logic                          rst,
   input  wire logic                          wr,
   input  wire logic [2:0]                    sel,
   input  wire logic [7:0]                    wdata,
   input  wire logic [2:0]                    rsel,
   output logic [7:0]                         rdata,
   output logic [uthf_pkg::HUB_BITS-1:0]      chg
);

   logic [7:0] reg_q [uthf_pkg::HUB_BITS];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < uthf_pkg::HUB_BITS; i++) begin
            reg_q[i] <= 8'h00;
         end
      end else if (wr && (sel < 3'(uthf_pkg::HUB_BITS))) begin
         reg_q[sel] <= wdata;
      end
   end

   // Bit falls only when its cause register is cleared
   always_comb begin
      for (int i = 0; i < uthf_pkg::HUB_BITS; i++) begin
         chg[i] = |reg_q[i];
      end
   end

   assign rdata = (rsel < 3'(uthf_pkg::HUB_BITS)) ? reg_q[rsel] : 8'h00;

endmodule

// ==== bench/uthf_tx_port_asserts.sv ====
// Port checker of the transmit port and hub change byte.
// Bound to every uthf_tx_port; one clock, async reset.
module uthf_tx_port_asserts (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       tok_valid,
   input wire logic [7:0] tok_ep,
   input wire logic       rd_req,
   input wire logic [7:0] rd_ep,
   input wire logic       rd_valid,
   input wire logic       hub_send,
   input wire logic [7:0] hub_byte,
   input wire logic       nak
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_hub_tok;
      tok_valid && tok_ep == 8'h81;
   endsequence
   property p_ready;
      s_setup |=> pready;
   endproperty
   property p_ready_one;
      pready |=> !pready;
   endproperty
   property p_answer;
      s_hub_tok |=> hub_send != nak;
   endproperty
   property p_send_nz;
      hub_send |-> hub_byte[4:0] != 5'h00;
   endproperty
   property p_rsv;
      hub_send |-> hub_byte[7:5] == 3'h0;
   endproperty
   property p_other;
      tok_valid && tok_ep != 8'h81 |=> !hub_send && !nak;
   endproperty
   property p_cause;
      hub_send || nak |-> $past(tok_valid) && $past(tok_ep) == 8'h81;
   endproperty
   property p_rd;
      rd_valid |-> $past(rd_req) && $past(rd_ep) != 8'h81;
   endproperty
   a_ready: assert property (p_ready)
      else $error("no ready after setup");
   a_ready_one: assert property (p_ready_one)
      else $error("ready held too long");
   a_answer: assert property (p_answer)
      else $error("hub token answer wrong");
   a_send_nz: assert property (p_send_nz)
      else $error("hub byte sent empty");
   a_rsv: assert property (p_rsv)
      else $error("reserved hub bits set");
   a_other: assert property (p_other)
      else $error("answer to other endpoint");
   a_cause: assert property (p_cause)
      else $error("hub answer without token");
   a_rd: assert property (p_rd)
      else $error("byte without request");
endmodule

bind uthf_tx_port uthf_tx_port_asserts u_chk (.clk, .rst, .psel,
   .penable, .pready, .tok_valid, .tok_ep, .rd_req, .rd_ep, .rd_valid,
   .hub_send, .hub_byte, .nak);

// ==== bench/uthf_engine_model.sv ====
// Interface engine model: IN tokens, byte reads, marker advances.
// Shares the port's clock; answers sampled one cycle after a request.
module uthf_engine_model (
   input  wire logic       clk,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid,
   input  wire logic       hub_send,
   input  wire logic [7:0] hub_byte,
   input  wire logic       nak,
   output logic            tok_valid,
   output logic [7:0]      tok_ep,
   output logic            rd_req,
   output logic [7:0]      rd_ep,
   output logic            adv_valid,
   output logic [7:0]      adv_ep
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      tok_valid = 1'b0;
      rd_req = 1'b0;
      adv_valid = 1'b0;
      tok_ep = 8'h00;
      rd_ep = 8'h00;
      adv_ep = 8'h00;
   end
   task automatic token(input logic [7:0] ep, output logic [9:0] r);
      @(posedge clk);
      tok_valid <= 1'b1;
      tok_ep <= ep;
      @(posedge clk);
      tok_valid <= 1'b0;
      tok_ep <= ~ep;
      #1;
      r = {hub_send, nak, hub_byte};
   endtask
   task automatic rd(input logic [7:0] ep, output logic [8:0] r);
      @(posedge clk);
      rd_req <= 1'b1;
      rd_ep <= ep;
      @(posedge clk);
      rd_req <= 1'b0;
      rd_ep <= ~ep;
      #1;
      r = {rd_valid, rd_data};
   endtask
   task automatic adv(input logic [7:0] ep);
      @(posedge clk);
      adv_valid <= 1'b1;
      adv_ep <= ep;
      @(posedge clk);
      adv_valid <= 1'b0;
      adv_ep <= ~ep;
   endtask
endmodule

// ==== bench/usb_tx_fifo_hub_status_port_tb.sv ====
// Self-checking bench of the transmit port and hub change byte.
// Drives APB itself; the engine model plays the interface engine.
module usb_tx_fifo_hub_status_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] DP = uthf_pkg::IDX_TX_BYTE_PORT;
   localparam logic [9:0] SEL = uthf_pkg::IDX_ENDPOINT_SEL;
   localparam logic [9:0] CHG = uthf_pkg::IDX_PORT_CHANGE_0;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic        tok_valid, rd_req, adv_valid, rd_valid, hub_send, nak;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [7:0]  tok_ep, rd_ep, adv_ep, rd_data, hub_byte;
   logic [9:0]  tr;
   logic [8:0]  rr;
   int          err_count, compares;
   uthf_tx_port dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tok_valid, .tok_ep, .rd_req,
      .rd_ep, .rd_data, .rd_valid, .adv_valid, .adv_ep, .hub_send,
      .hub_byte, .nak, .irq);
   uthf_engine_model eng (.clk, .rd_data, .rd_valid, .hub_send,
      .hub_byte, .nak, .tok_valid, .tok_ep, .rd_req, .rd_ep, .adv_valid,
      .adv_ep);
   task automatic summarize();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] i,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         summarize();
      end
      rv = {prdata[31:1], prdata[0]};
      chk({31'h0, pslverr}, {31'h0, i == 10'h000});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_hub();
      apb(1, SEL, 32'h81);
      apb(0, DP, 0);
      chk(rv, 32'h0);
      for (int i = 0; i < 5; i++) begin
         apb(1, CHG + 10'(i), 32'h80 >> i);
         apb(1, DP, 32'h00);
         apb(0, DP, 0);
         chk(rv, 32'h1 << i);
         eng.token(8'h81, tr);
         chk({22'h0, tr}, {22'h0, 2'b10, 8'(1 << i)});
         apb(1, CHG + 10'(i), 32'h0);
         apb(0, DP, 0);
         chk(rv, 32'h0);
         eng.token(8'h81, tr);
         chk({30'h0, tr[9:8]}, 32'h1);
      end
   endtask
   task automatic t_fifo();
      apb(1, SEL, 32'h01);
      for (int i = 0; i < 3; i++) apb(1, DP, 32'hA0 + i);
      for (int i = 0; i < 3; i++) begin
         eng.rd(8'h01, rr);
         chk({23'h0, rr}, 32'h1A0 + i);
      end
      eng.rd(8'h01, rr);
      chk({31'h0, rr[8]}, 32'h0);
      eng.token(8'h01, tr);
      chk({30'h0, tr[9:8]}, 32'h0);
      apb(1, SEL, 32'h80);
      apb(1, DP, 32'h5C);
      eng.rd(8'h80, rr);
      chk({23'h0, rr}, 32'h15C);
   endtask
   task automatic t_flags();
      logic [1:0] e [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
      apb(1, SEL, 32'h01);
      for (int k = 0; k < 4; k++) begin
         if (k < 2) apb(1, uthf_pkg::IDX_TX_BYTE_COUNT, 0);
         else if (k == 2) eng.adv(8'h01);
         else apb(1, uthf_pkg::IDX_ADVANCE_MARKER, 0);
         apb(0, uthf_pkg::IDX_TX_FLAG_REG, 0);
         chk({30'h0, rv[7:6]}, {30'h0, e[k]});
      end
   endtask
   task automatic t_full();
      apb(1, SEL, 32'h02);
      apb(0, uthf_pkg::IDX_TX_FLAG_REG, 0);
      chk(rv & 32'hC, 32'h8);
      for (int i = 0; i < 8; i++) apb(1, DP, 32'h30 + i);
      apb(0, uthf_pkg::IDX_TX_FLAG_REG, 0);
      chk(rv & 32'hC, 32'h4);
      apb(1, uthf_pkg::IDX_IRQ_CLEAR, 32'h7);
      apb(1, DP, 32'hEE);
      apb(1, CHG + 10'd3, 32'h1);
      apb(0, CHG + 10'd3, 0);
      chk(rv, 32'h1);
      apb(0, uthf_pkg::IDX_IRQ_STATUS, 0);
      chk(rv, 32'h5);
      apb(1, CHG + 10'd3, 32'h0);
      for (int i = 0; i < 8; i++) begin
         eng.rd(8'h02, rr);
         chk({23'h0, rr}, 32'h130 + i);
      end
   endtask
   task automatic irq_is(input logic [9:0] i, input logic [31:0] d,
                         input logic x);
      apb(1, i, d);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, {31'h0, x});
   endtask
   task automatic t_irq();
      irq_is(uthf_pkg::IDX_IRQ_CLEAR, 32'h7, 1'b0);
      irq_is(uthf_pkg::IDX_IRQ_ENABLE, 32'h2, 1'b0);
      eng.token(8'h81, tr);
      apb(0, uthf_pkg::IDX_IRQ_STATUS, 0);
      chk(rv & 32'h2, 32'h2);
      irq_is(uthf_pkg::IDX_IRQ_ENABLE, 32'h0, 1'b0);
      irq_is(uthf_pkg::IDX_IRQ_ENABLE, 32'h2, 1'b1);
      irq_is(uthf_pkg::IDX_IRQ_CLEAR, 32'h2, 1'b0);
      apb(0, 10'h000, 0);
      chk(rv, 32'h0);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      err_count = 0;
      compares = 0;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_hub();
      t_fifo();
      t_flags();
      t_full();
      t_irq();
      summarize();
   end
endmodule
